// *** hdl/psa_consts.svh ***
// Constants for the operand address generator: register numbers, modes, steps, reset values
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH
`define PSA_REG_PROGRAM_COUNTER 3'h7
`define PSA_REG_STACK_POINTER 3'h6
`define PSA_MODE_REGISTER 3'h0
`define PSA_MODE_DEFERRED 3'h1
`define PSA_MODE_AUTOINC 3'h2
`define PSA_MODE_AUTOINC_DEF 3'h3
`define PSA_MODE_AUTODEC 3'h4
`define PSA_MODE_AUTODEC_DEF 3'h5
`define PSA_MODE_INDEX 3'h6
`define PSA_MODE_INDEX_DEF 3'h7
`define PSA_WORD_STEP 16'h0002
`define PSA_BYTE_STEP 16'h0001
`define PSA_PC_RESET 16'h0000
`define PSA_SP_RESET 16'h0000
`define PSA_MODE_BIT 1
`endif

// *** hdl/psa_pkg.sv ***
// Types shared by the operand address generator
`default_nettype none
package psa_pkg;
	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] regnum;
	} psa_spec_t;
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} psa_mem_req_t;
	typedef enum logic [1:0] {
		PSA_ACT_NONE,
		PSA_ACT_INC,
		PSA_ACT_DEC
	} psa_step_t;
endpackage
`default_nettype wire

// *** hdl/psa_step_calc.sv ***
// Pointer step size and post/pre-modified value for one register
`include "psa_consts.svh"
`default_nettype none
module psa_step_calc (
	// Request
	input wire logic [2:0] i_regnum,
	input wire logic i_byte_op,
	input wire psa_pkg::psa_step_t i_action,
	input wire logic [15:0] i_value,
	// Result
	output logic [15:0] o_value
);
	import psa_pkg::*;
	wire logic word_only = (i_regnum == `PSA_REG_PROGRAM_COUNTER) ||
		(i_regnum == `PSA_REG_STACK_POINTER);
	// Stack and program counter never go odd, so byte ops still step by two
	wire logic [15:0] step = (i_byte_op && !word_only) ? `PSA_BYTE_STEP : `PSA_WORD_STEP; // RULE3 RULE10
	assign o_value = (i_action == PSA_ACT_INC) ? i_value + step :
		(i_action == PSA_ACT_DEC) ? i_value - step : i_value;
endmodule
`default_nettype wire

// *** hdl/psa_operand_addresser.sv ***
// Operand address generation for program counter and stack pointer modes
// What this block does
// (RULE1) Register seven is the program counter yet accepts every addressing mode.
// (RULE2) Each memory word read through the program counter advances it by two.
// (RULE3) Byte operands located through the program counter still advance it by two.
// (RULE4) Immediate is autoincrement through the program counter; source field 27.
// (RULE5) Immediate: fetch instruction, add two, read operand, add two again.
// (RULE6) Absolute: following word is the operand address; counter steps past it.
// (RULE7) Relative: operand address is index word plus current program counter.
// (RULE8) Relative index word is second or third instruction word, fetched in place.
// (RULE9) Relative deferred: index plus counter points at the operand address.
// (RULE10) Stack pointer autoincrement and autodecrement always step by two.
// (RULE11) Index mode with stack pointer adds an index word to it.
// (RULE12) With memory management two stack pointers exist, status word selects one.
// (RULE13) Relative deferred adds index to counter value after index fetch.
// (RULE14) Special program counter modes: register seven with mode 2, 3, 6 or 7.
`include "psa_consts.svh"
`default_nettype none
module psa_operand_addresser #(
	parameter int ADDR_WIDTH = 16
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Operand request from the decoder
	input wire logic i_start,
	input wire psa_pkg::psa_spec_t i_spec,
	input wire logic i_byte_op,
	input wire logic i_mmu_present,
	input wire logic i_ps_user_mode,
	// Program counter load (jumps, traps)
	input wire logic i_pc_load,
	input wire logic [15:0] i_pc_value,
	// Memory read port
	output psa_pkg::psa_mem_req_t o_mem_req,
	input wire logic i_mem_ack,
	input wire logic [15:0] i_mem_data,
	// Results
	output logic o_busy,
	output logic o_done,
	output logic o_is_register,
	output logic [15:0] o_operand_addr,
	output logic o_pc_special,
	output logic [15:0] o_program_counter,
	output logic [15:0] o_stack_pointer
);
	import psa_pkg::*;

	// Steps and sums are written for 16-bit words; other widths are refused
	if (ADDR_WIDTH != 16) begin : g_width_check
		$error("psa_operand_addresser supports only a 16-bit address");
	end

	// ****************************************
	// Decode
	// ****************************************
	function automatic logic mode_is_pc_special(input psa_spec_t s);
		return (s.regnum == `PSA_REG_PROGRAM_COUNTER) &&
			(s.mode == `PSA_MODE_AUTOINC || s.mode == `PSA_MODE_AUTOINC_DEF ||
			s.mode == `PSA_MODE_INDEX || s.mode == `PSA_MODE_INDEX_DEF); // RULE14
	endfunction

	// Mode classes, shared by the sequencer and the pointer stepping
	function automatic logic mode_is_autoinc(input logic [2:0] m);
		return (m == `PSA_MODE_AUTOINC) || (m == `PSA_MODE_AUTOINC_DEF);
	endfunction

	function automatic logic mode_is_autodec(input logic [2:0] m);
		return (m == `PSA_MODE_AUTODEC) || (m == `PSA_MODE_AUTODEC_DEF);
	endfunction

	function automatic logic mode_is_index(input logic [2:0] m);
		return (m == `PSA_MODE_INDEX) || (m == `PSA_MODE_INDEX_DEF);
	endfunction

	typedef enum {
		S_IDLE,
		S_PREDEC,
		S_READ_INDEX,
		S_READ_PTR,
		S_DONE
	} state_t;
	state_t state;
	state_t next_state;

	psa_spec_t spec;
	logic byte_op;
	logic [15:0] program_counter;
	logic [15:0] kernel_sp;
	logic [15:0] user_sp;
	logic [15:0] gpr [0:5];
	logic [15:0] addr;
	logic done;

	// Only one stack pointer is live at a time; with memory management present the status word picks it, else the kernel one
	wire logic use_user_sp = i_mmu_present && i_ps_user_mode; // RULE12
	wire logic [15:0] active_sp = use_user_sp ? user_sp : kernel_sp; // RULE12

	// All eight registers in one word: a continuous assignment that calls a function
	// wakes only on its arguments, so the live values must be passed in
	wire logic [127:0] reg_bank = {program_counter, active_sp, gpr[5], gpr[4],
		gpr[3], gpr[2], gpr[1], gpr[0]};

	function automatic logic [15:0] read_reg(input logic [2:0] r, input logic [127:0] bank);
		// Register seven is the program counter, six the live stack pointer
		return bank[{r, 4'h0} +: 16]; // RULE1
	endfunction

	wire logic [2:0] mode = spec.mode;
	wire logic [2:0] regnum = spec.regnum;
	wire logic [15:0] reg_value = read_reg(regnum, reg_bank);
	wire logic is_deferred = mode[0];
	// A read completes only at the edge where valid and acknowledge meet
	wire logic mem_fire = o_mem_req.valid && i_mem_ack;

	// ****************************************
	// Pointer stepping
	// ****************************************
	psa_step_t step_action;
	logic [15:0] stepped;
	assign step_action = (state == S_PREDEC) ? PSA_ACT_DEC :
		(state == S_IDLE && i_start && mode_is_autoinc(i_spec.mode)) ? PSA_ACT_INC :
		PSA_ACT_NONE;
	wire logic [2:0] step_reg = (state == S_IDLE) ? i_spec.regnum : regnum;
	wire logic step_byte = (state == S_IDLE) ? i_byte_op : byte_op;
	// Autoincrement deferred always steps a whole word
	wire logic step_byte_eff = step_byte &&
		!((state == S_IDLE) ? i_spec.mode[0] : spec.mode[0]);
	wire logic [15:0] step_src = (state == S_IDLE) ? read_reg(i_spec.regnum, reg_bank) :
		reg_value;

	psa_step_calc u_step (
		.i_regnum(step_reg),
		.i_byte_op(step_byte_eff),
		.i_action(step_action),
		.i_value(step_src),
		.o_value(stepped)
	);

	// Request decode, meaningful only while idle
	wire logic start_take = (state == S_IDLE) && i_start;
	wire logic start_reg = i_start && (i_spec.mode == `PSA_MODE_REGISTER);
	wire logic start_inc = i_start && mode_is_autoinc(i_spec.mode);
	wire logic start_dec = i_start && mode_is_autodec(i_spec.mode);
	wire logic start_index = i_start && mode_is_index(i_spec.mode);
	// Only autoincrement deferred reads a pointer at once; register deferred has
	// its address in the register already and needs no bus cycle
	wire logic start_ptr = i_start && (i_spec.mode == `PSA_MODE_AUTOINC_DEF);
	// Immediate (27) is autoincrement and absolute (37) autoincrement deferred through the counter
	wire logic [15:0] start_addr = read_reg(i_spec.regnum, reg_bank); // RULE4 RULE6

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: begin
				if (i_start) begin
					if (start_dec)
						next_state = S_PREDEC;
					else if (start_index)
						next_state = S_READ_INDEX; // RULE7 RULE11
					else if (start_ptr)
						next_state = S_READ_PTR; // RULE6
					else
						next_state = S_DONE;
				end
			end
			S_PREDEC:
				next_state = is_deferred ? S_READ_PTR : S_DONE;
			S_READ_INDEX: begin
				if (mem_fire)
					next_state = is_deferred ? S_READ_PTR : S_DONE;
			end
			S_READ_PTR: begin
				if (mem_fire)
					next_state = S_DONE;
			end
			S_DONE:
				next_state = S_IDLE;
		endcase
	end

	// Index word sits at the counter, which already points past any earlier word
	wire logic [15:0] next_pc_after_index = program_counter + `PSA_WORD_STEP; // RULE2 RULE8
	// Counter value used is the one after the index fetch (instruction + 4, or + 6 for a third-word index)
	wire logic [15:0] index_base = (regnum == `PSA_REG_PROGRAM_COUNTER) ?
		next_pc_after_index : reg_value; // RULE7 RULE13
	wire logic [15:0] index_sum = index_base + i_mem_data; // RULE7 RULE9 RULE11

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Done is a one-cycle pulse in the cycle the sequencer sits in S_DONE
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			done <= 1'b0;
		end else begin
			done <= (next_state == S_DONE);
		end
	end

	// The request is captured once; later states work from the copy
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			spec <= '0;
			byte_op <= 1'b0;
			o_is_register <= 1'b0;
			o_pc_special <= 1'b0;
		end else if (start_take) begin
			spec <= i_spec;
			byte_op <= i_byte_op;
			o_is_register <= start_reg;
			o_pc_special <= mode_is_pc_special(i_spec); // RULE14
		end
	end

	// One address register serves every step; it holds until the next start
	wire logic [15:0] next_addr = start_take ? start_addr :
		(state == S_PREDEC) ? stepped :
		(state == S_READ_INDEX && mem_fire) ? index_sum : // RULE7 RULE9 RULE11
		(state == S_READ_PTR && mem_fire) ? i_mem_data : // RULE6 RULE9
		addr;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			addr <= 16'h0000;
		end else begin
			addr <= next_addr;
		end
	end

	// ****************************************
	// Register updates
	// ****************************************
	wire logic pc_step = (state == S_IDLE && start_inc &&
		i_spec.regnum == `PSA_REG_PROGRAM_COUNTER) ||
		(state == S_PREDEC && regnum == `PSA_REG_PROGRAM_COUNTER);
	wire logic sp_step = (state == S_IDLE && start_inc &&
		i_spec.regnum == `PSA_REG_STACK_POINTER) ||
		(state == S_PREDEC && regnum == `PSA_REG_STACK_POINTER);
	// Every index word comes through the counter, whatever register it indexes
	wire logic pc_index_fetch = (state == S_READ_INDEX) && mem_fire; // RULE2 RULE8

	// A jump or trap load outranks any step in the same cycle
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			program_counter <= `PSA_PC_RESET;
		end else if (i_pc_load) begin
			program_counter <= i_pc_value;
		end else if (pc_step) begin
			program_counter <= stepped; // RULE2 RULE3 RULE5
		end else if (pc_index_fetch) begin
			program_counter <= next_pc_after_index; // RULE2 RULE8
		end
	end

	// A step goes to whichever pointer is live in that cycle: user only with memory management present and user mode in the status word
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			kernel_sp <= `PSA_SP_RESET;
			user_sp <= `PSA_SP_RESET;
		end else if (sp_step) begin
			if (use_user_sp)
				user_sp <= stepped; // RULE10 RULE12
			else
				kernel_sp <= stepped; // RULE10 RULE12
		end
	end

	wire logic gpr_step = (state == S_IDLE && start_inc && i_spec.regnum < 3'h6) ||
		(state == S_PREDEC && regnum < 3'h6);
	wire logic [2:0] gpr_sel = (state == S_IDLE) ? i_spec.regnum : regnum;

	// Loads of registers zero to five belong to the data path; only steps land here
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < 6; i++)
				gpr[i] <= 16'h0000;
		end else if (gpr_step) begin
			gpr[gpr_sel] <= stepped;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// The read address is the counter itself for index words, else the held pointer
	// The request stands until acknowledged, since the read states wait for it
	assign o_mem_req.valid = (state == S_READ_INDEX) || (state == S_READ_PTR);
	assign o_mem_req.addr = (state == S_READ_INDEX) ? program_counter : addr; // RULE8
	assign o_busy = (state != S_IDLE);
	assign o_done = done;
	assign o_operand_addr = addr;
	assign o_program_counter = program_counter;
	assign o_stack_pointer = active_sp;
endmodule
`default_nettype wire

// *** bench/psa_operand_addresser_properties.sv ***
// Assertion checker for the operand address generator
`default_nettype none
module psa_props #(
	parameter int ADDR_WIDTH = 16
) (
	// Clock, reset and requests
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_start,
	input wire psa_pkg::psa_spec_t i_spec,
	input wire logic i_mmu_present,
	input wire logic i_ps_user_mode,
	input wire logic i_pc_load,
	input wire logic i_mem_ack,
	input wire logic [15:0] i_mem_data,
	// Design outputs
	input wire psa_pkg::psa_mem_req_t o_mem_req,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic [15:0] o_operand_addr,
	input wire logic o_pc_special,
	input wire logic [15:0] o_program_counter,
	input wire logic [15:0] o_stack_pointer
);
	timeunit 1ns;
	timeprecision 1ns;
	import psa_pkg::*;
	psa_spec_t spec;
	logic [15:0] idx;
	logic acks;
	wire logic go = i_start && !o_busy;
	wire logic rd = o_mem_req.valid && i_mem_ack;
	// ***
	// Helper state: request kind and last word read
	// ***
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			spec <= '0;
			idx <= '0;
			acks <= 1'b0;
		end else if (go) begin
			spec <= i_spec;
			acks <= 1'b0;
		end else if (rd) begin
			idx <= i_mem_data;
			acks <= 1'b1;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	a_pc_step_two:
	assert property ($changed(o_program_counter) && !$past(i_pc_load) |->
		16'(o_program_counter - $past(o_program_counter)) inside {16'h0002, 16'hfffe})
		else $error("pc step not two");
	a_sp_step_two:
	assert property ($changed(o_stack_pointer) && $stable(i_ps_user_mode) &&
		$stable(i_mmu_present) |->
		16'(o_stack_pointer - $past(o_stack_pointer)) inside {16'h0002, 16'hfffe})
		else $error("sp step not two");
	a_imm_operand:
	assert property (go && i_spec == 6'h17 |=> o_done &&
		o_operand_addr == $past(o_program_counter) &&
		o_program_counter == $past(o_program_counter) + 16'h0002)
		else $error("immediate wrong");
	a_abs_operand:
	assert property (rd && spec == 6'h1f |=> o_done && o_operand_addr == $past(i_mem_data))
		else $error("absolute wrong");
	a_rel_operand:
	assert property (rd && spec == 6'h37 |=> o_done &&
		o_operand_addr == o_program_counter + $past(i_mem_data))
		else $error("relative wrong");
	a_index_at_pc:
	assert property (o_mem_req.valid && spec.regnum == 3'h7 && spec.mode[2:1] == 2'h3 && !acks
		|-> o_mem_req.addr == o_program_counter)
		else $error("index read not at pc");
	a_index_steps_pc:
	assert property (rd && !acks && spec.mode[2:1] == 2'h3 |=>
		o_program_counter == $past(o_program_counter) + 16'h0002)
		else $error("index fetch did not step pc");
	a_reldef_pointer:
	assert property (o_mem_req.valid && spec == 6'h3f && acks |->
		o_mem_req.addr == o_program_counter + idx)
		else $error("deferred pointer wrong");
	a_sp_index:
	assert property (rd && spec == 6'h36 |=> o_done &&
		o_operand_addr == o_stack_pointer + $past(i_mem_data))
		else $error("sp index wrong");
	a_special_decode:
	assert property (o_done |-> o_pc_special ==
		(spec.regnum == 3'h7 && spec.mode inside {3'h2, 3'h3, 3'h6, 3'h7}))
		else $error("special decode wrong");
	a_start_answered:
	assert property (go |-> ##[1:40] o_done)
		else $error("no answer");
	c_imm: cover property (go && i_spec == 6'h17);
	c_reldef: cover property (o_done && spec == 6'h3f);
	c_push: cover property (o_done && spec == 6'h26);
	c_sp_index: cover property (o_done && spec == 6'h36);
endmodule
bind psa_operand_addresser psa_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.*);
`default_nettype wire

// *** bench/psa_mem_model.sv ***
// Memory model answering the read port after a set number of wait cycles
`default_nettype none
module psa_mem_model (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Read port
	input wire psa_pkg::psa_mem_req_t i_req,
	input wire logic [3:0] i_wait,
	output logic o_ack,
	output logic [15:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n)
			cnt <= '0;
		else if (!i_req.valid || o_ack)
			cnt <= '0;
		else
			cnt <= cnt + 4'h1;
	end
	assign o_ack = i_req.valid && cnt == i_wait;
	// Word at address a holds a + 100h; inverted off ack so stale data never matches
	assign o_data = o_ack ? i_req.addr + 16'h0100 : ~(i_req.addr + 16'h0100);
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the operand address generator
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import psa_pkg::*;
	logic i_clock = 0, i_reset_n = 0, i_start = 0, i_byte_op = 0;
	logic i_mmu_present = 0, i_ps_user_mode = 0, i_pc_load = 0;
	logic [15:0] i_pc_value = '0;
	psa_spec_t i_spec = '0;
	psa_mem_req_t o_mem_req;
	logic i_mem_ack, o_busy, o_done, o_is_register, o_pc_special;
	logic [15:0] i_mem_data, o_operand_addr, o_program_counter, o_stack_pointer;
	logic [3:0] wait_n = 0;
	int n_errors = 0, num_checks = 0, cycles = 0;
	always #50 i_clock = ~i_clock;
	psa_operand_addresser u_dut (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_start(i_start),
		.i_spec(i_spec),
		.i_byte_op(i_byte_op),
		.i_mmu_present(i_mmu_present),
		.i_ps_user_mode(i_ps_user_mode),
		.i_pc_load(i_pc_load),
		.i_pc_value(i_pc_value),
		.o_mem_req(o_mem_req),
		.i_mem_ack(i_mem_ack),
		.i_mem_data(i_mem_data),
		.o_busy(o_busy),
		.o_done(o_done),
		.o_is_register(o_is_register),
		.o_operand_addr(o_operand_addr),
		.o_pc_special(o_pc_special),
		.o_program_counter(o_program_counter),
		.o_stack_pointer(o_stack_pointer)
	);
	psa_mem_model u_mem (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_req(o_mem_req),
		.i_wait(wait_n), .o_ack(i_mem_ack), .o_data(i_mem_data));
	// ***
	// Shared tasks
	// ***
	task automatic chk(input string what, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic set_pc(input logic [15:0] v);
		@(posedge i_clock);
		i_pc_load <= 1'b1;
		i_pc_value <= v;
		@(posedge i_clock);
		i_pc_load <= 1'b0;
	endtask
	task automatic op(input logic [5:0] s, input logic b);
		@(posedge i_clock);
		i_spec <= s;
		i_byte_op <= b;
		i_start <= 1'b1;
		@(posedge i_clock);
		i_start <= 1'b0;
		for (int k = 0; k < 50; k++) begin
			@(negedge i_clock);
			if (o_done === 1'b1)
				break;
		end
		chk("done", {15'h0, o_done}, 16'h0001);
		chk("busy", {15'h0, o_busy}, 16'h0001);
	endtask
	// ***
	// Scenarios
	// ***
	task automatic t_pc_modes();
		set_pc(16'h1000);
		op(6'h17, 1'b1);
		chk("imm addr", o_operand_addr, 16'h1000);
		chk("imm pc", o_program_counter, 16'h1002);
		wait_n = 4'h2;
		set_pc(16'h2000);
		op(6'h1f, 1'b0);
		chk("abs addr", o_operand_addr, 16'h2100);
		chk("abs pc", o_program_counter, 16'h2002);
		wait_n = 4'h0;
		set_pc(16'h3000);
		op(6'h37, 1'b0);
		chk("rel addr", o_operand_addr, 16'h6102);
		op(6'h37, 1'b0);
		chk("rel third word", o_operand_addr, 16'h6106);
		wait_n = 4'h1;
		set_pc(16'h0400);
		op(6'h3f, 1'b0);
		chk("reldef addr", o_operand_addr, 16'h0a02);
		chk("reldef pc", o_program_counter, 16'h0402);
		$display("pc mode test done");
	endtask
	task automatic t_stack();
		op(6'h26, 1'b1);
		chk("push addr", o_operand_addr, 16'hfffe);
		op(6'h16, 1'b1);
		chk("pop sp", o_stack_pointer, 16'h0000);
		set_pc(16'h0200);
		op(6'h36, 1'b0);
		chk("sp index", o_operand_addr, 16'h0300);
		chk("sp index pc", o_program_counter, 16'h0202);
		@(posedge i_clock);
		i_mmu_present <= 1'b1;
		i_ps_user_mode <= 1'b1;
		op(6'h26, 1'b0);
		chk("user sp", o_stack_pointer, 16'hfffe);
		@(posedge i_clock);
		i_ps_user_mode <= 1'b0;
		@(negedge i_clock);
		chk("kernel sp", o_stack_pointer, 16'h0000);
		$display("stack test done");
	endtask
	task automatic t_decode();
		for (int m = 0; m < 8; m++) begin
			set_pc(16'h0800);
			op({m[2:0], 3'h7}, 1'b0);
			chk("special", {15'h0, o_pc_special}, 16'(m inside {2, 3, 6, 7}));
			chk("is reg", {15'h0, o_is_register}, 16'(m == 0));
			if (m == 1)
				chk("reg deferred addr", o_operand_addr, 16'h0800);
		end
		$display("decode test done");
	endtask
	always @(posedge i_clock) begin
		cycles++;
		// Whole run needs well under 1000 cycles
		if (cycles == 5000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge i_clock);
		i_reset_n <= 1'b1;
		t_pc_modes();
		t_stack();
		t_decode();
		close_out();
	end
endmodule
`default_nettype wire
